// ===== design/supply_state_and_irq_flags.sv
// Power state machine, oscillator steering and interrupt flag servicing
// How it works
// (R01) Clear-on-read status read returns then clears flags
// (R02) Events near clearing read are never lost
// (R03) Writing zero clears a flag
// (R04) Software rereads status until all zero
// (R05) Oscillator flags untouched by clear-on-read
// (R06) Autocal failure raises enabled interrupt
// (R07) Power-on state holds registers at reset
// (R08) Main above start enters main state
// (R09) Main below reset without backup: reset
// (R10) Backup alone never leaves power-on state
// (R11) Backup crossing only arms switchover
// (R12) Main below switch-fall, backup good: backup
// (R13) Main above switch-rise returns to main
// (R14) Backup below reset level: power-on state
// (R15) Entering backup sets read-only backup flag
// (R16) Backup state forces RC when enabled
// (R17) Crystal failure forces RC when enabled
// (R18) Serial accesses ignored on backup unless allowed
// (R19) Polarity picks falling or rising crossing
// (R20) Cell-low interrupt when flag and enable
// (R21) Above-threshold bit with hysteresis
// (R22) Software settles, clears flag, checks level
// (R23) Software reset after power up advised
// (R24) Level interrupts stay until flag cleared
// (R25) Comparators synchronised, changes on clock edge
`timescale 1ns/1ns
module supply_state_and_irq_flags #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic main_above_start_level,
  input wire logic main_below_reset_level,
  input wire logic main_below_switch_fall_level,
  input wire logic main_above_switch_rise_level,
  input wire logic backup_above_switch_level,
  input wire logic backup_below_reset_level,
  input wire logic backup_above_rise_threshold,
  input wire logic backup_below_fall_threshold,
  input wire logic watchdog_event,
  input wire logic countdown_event,
  input wire logic alarm_event,
  input wire logic external_event,
  input wire logic xtal_fail_event,
  input wire logic autocal_fail_event,
  output logic [1:0] power_state,
  output logic hold_in_reset,
  output logic on_backup_supply_flag,
  output logic use_rc_osc,
  output logic [1:0] autocal_mode,
  output logic serial_enable,
  output logic [3:0] backup_threshold_select,
  output logic backup_above_threshold,
  output logic cell_low_irq,
  output logic xtal_fail_irq,
  output logic autocal_fail_irq
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  generate
    if (ADDR_W != 8 || DATA_W != 8) begin : g_bad_width
      $error("supply_state_and_irq_flags needs 8-bit address and data");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Comparator synchronisers
  // ----------------------------------------------------------------
  localparam int NUM_CMP = 8;
  logic [NUM_CMP-1:0] cmp_raw;
  logic [NUM_CMP-1:0] cmp_meta;
  logic [NUM_CMP-1:0] cmp_sync;

  assign cmp_raw = {backup_below_fall_threshold, backup_above_rise_threshold,
                    backup_below_reset_level, backup_above_switch_level,
                    main_above_switch_rise_level, main_below_switch_fall_level,
                    main_below_reset_level, main_above_start_level};

  // (R25) Two-stage comparator sync
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_sync
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          cmp_meta[gi] <= 1'b0;
          cmp_sync[gi] <= 1'b0;
        end else begin
          cmp_meta[gi] <= cmp_raw[gi];
          cmp_sync[gi] <= cmp_meta[gi];
        end
      end
    end
  endgenerate

  logic main_start, main_low, main_fall, main_rise;
  logic backup_ok, backup_low, above_rise, below_fall;

  assign {below_fall, above_rise, backup_low, backup_ok,
          main_rise, main_fall, main_low, main_start} = cmp_sync;

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  supply_state_pkg::power_state_t state;
  supply_state_pkg::power_state_t next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      supply_state_pkg::PWR_POR: begin
        // (R08) Start on main supply
        // (R10) Backup alone keeps reset
        if (main_start) begin
          next_state = supply_state_pkg::PWR_MAIN;
        end
      end
      supply_state_pkg::PWR_MAIN: begin
        // (R12) Switch to backup supply
        // (R11) Backup crossing only arms
        if (main_fall && backup_ok) begin
          next_state = supply_state_pkg::PWR_BACKUP;
        // (R09) Main collapse without backup
        end else if (main_low && !backup_ok) begin
          next_state = supply_state_pkg::PWR_POR;
        end
      end
      supply_state_pkg::PWR_BACKUP: begin
        // (R13) Return on switch-rise
        if (main_rise) begin
          next_state = supply_state_pkg::PWR_MAIN;
        // (R14) Backup exhausted
        end else if (backup_low) begin
          next_state = supply_state_pkg::PWR_POR;
        end
      end
      default: begin
        next_state = supply_state_pkg::PWR_POR;
      end
    endcase
  end

  // (R25) State changes on clock edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= supply_state_pkg::PWR_POR;
    end else begin
      state <= next_state;
    end
  end

  logic in_por, in_backup;
  assign in_por = (state == supply_state_pkg::PWR_POR);
  assign in_backup = (state == supply_state_pkg::PWR_BACKUP);
  assign power_state = state;
  assign hold_in_reset = in_por;
  // (R15) Backup flag follows state
  assign on_backup_supply_flag = in_backup;

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  logic [7:0] control;
  logic [7:0] irq_mask;
  logic [7:0] osc_control;
  logic [3:0] threshold;
  logic serial_on_backup;

  // (R18) Gate serial accesses on backup
  assign serial_enable = !in_por && !(in_backup && !serial_on_backup);

  function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] off);
    hit = strobe && serial_enable && (a == off);
  endfunction

  logic wr_status, rd_status, wr_osc_status;
  assign wr_status = hit(wr, addr, supply_state_pkg::ADDR_STATUS);
  assign rd_status = hit(rd, addr, supply_state_pkg::ADDR_STATUS);
  assign wr_osc_status = hit(wr, addr, supply_state_pkg::ADDR_OSC_STATUS);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // (R07) Held at reset values in power-on state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      control <= supply_state_pkg::RST_CONTROL;
      irq_mask <= supply_state_pkg::RST_IRQ_MASK;
      osc_control <= supply_state_pkg::RST_OSC_CONTROL;
      threshold <= supply_state_pkg::RST_THRESHOLD;
      serial_on_backup <= supply_state_pkg::RST_SERIAL_ON_BACKUP;
    end else if (in_por) begin
      control <= supply_state_pkg::RST_CONTROL;
      irq_mask <= supply_state_pkg::RST_IRQ_MASK;
      osc_control <= supply_state_pkg::RST_OSC_CONTROL;
      threshold <= supply_state_pkg::RST_THRESHOLD;
      serial_on_backup <= supply_state_pkg::RST_SERIAL_ON_BACKUP;
    end else begin
      if (hit(wr, addr, supply_state_pkg::ADDR_CONTROL)) begin
        control <= wdata;
      end
      if (hit(wr, addr, supply_state_pkg::ADDR_IRQ_MASK)) begin
        irq_mask <= wdata;
      end
      if (hit(wr, addr, supply_state_pkg::ADDR_OSC_CONTROL)) begin
        osc_control <= wdata;
      end
      if (hit(wr, addr, supply_state_pkg::ADDR_THRESHOLD)) begin
        threshold <= wdata[supply_state_pkg::THR_HI:supply_state_pkg::THR_LO];
      end
      if (hit(wr, addr, supply_state_pkg::ADDR_IO_BACKUP)) begin
        serial_on_backup <= wdata[supply_state_pkg::IOB_SERIAL_ON_BACKUP];
      end
    end
  end

  assign backup_threshold_select = threshold;

  // ----------------------------------------------------------------
  // Backup comparator hysteresis and cell-low crossing
  // ----------------------------------------------------------------
  logic above_thr;
  logic polarity;
  logic cell_low_event;
  assign polarity = control[supply_state_pkg::CTL_POLARITY];

  // (R21) Hysteresis on above-threshold bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      above_thr <= 1'b0;
    end else if (in_por) begin
      above_thr <= 1'b0;
    end else if (above_rise) begin
      above_thr <= 1'b1;
    end else if (below_fall) begin
      above_thr <= 1'b0;
    end
  end

  assign backup_above_threshold = above_thr;
  // (R19) Crossing direction by polarity
  assign cell_low_event = polarity ? (!above_thr && above_rise) : (above_thr && below_fall);

  // ----------------------------------------------------------------
  // Main status flags
  // ----------------------------------------------------------------
  localparam int NUM_FLAGS = 5;
  localparam int FLAG_POS [NUM_FLAGS] = '{supply_state_pkg::STS_WATCHDOG,
                                          supply_state_pkg::STS_CELL_LOW,
                                          supply_state_pkg::STS_COUNTDOWN,
                                          supply_state_pkg::STS_ALARM,
                                          supply_state_pkg::STS_EXTERNAL};
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] flag_event;
  logic clear_on_read;

  // Bit i pairs with FLAG_POS[i]
  assign flag_event = {external_event, alarm_event, countdown_event, cell_low_event,
                       watchdog_event};
  assign clear_on_read = control[supply_state_pkg::CTL_CLEAR_ON_READ];

  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          flags[gi] <= 1'b0;
        end else if (in_por) begin
          flags[gi] <= 1'b0;
        // (R02) Set wins over clear
        end else if (flag_event[gi]) begin
          flags[gi] <= 1'b1;
        // (R01) Clear after returning value
        end else if (rd_status && clear_on_read) begin
          flags[gi] <= 1'b0;
        // (R03) Write zero clears
        end else if (wr_status && !wdata[FLAG_POS[gi]]) begin
          flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Oscillator status flags
  // ----------------------------------------------------------------
  logic xtal_fail_flag;
  logic autocal_fail_flag;
  logic xt_fail_switched;

  // (R05) Cleared by direct write, never by clear-on-read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xtal_fail_flag <= supply_state_pkg::RST_XTAL_FAIL;
      autocal_fail_flag <= 1'b0;
    end else if (in_por) begin
      xtal_fail_flag <= supply_state_pkg::RST_XTAL_FAIL;
      autocal_fail_flag <= 1'b0;
    end else begin
      if (xtal_fail_event) begin
        xtal_fail_flag <= 1'b1;
      end else if (wr_osc_status && !wdata[supply_state_pkg::OST_XTAL_FAIL]) begin
        xtal_fail_flag <= 1'b0;
      end
      if (autocal_fail_event) begin
        autocal_fail_flag <= 1'b1;
      end else if (wr_osc_status && !wdata[supply_state_pkg::OST_AUTOCAL_FAIL]) begin
        autocal_fail_flag <= 1'b0;
      end
    end
  end

  // (R17) Crystal failure latches RC
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xt_fail_switched <= 1'b0;
    end else if (in_por) begin
      xt_fail_switched <= 1'b0;
    end else if (xtal_fail_event && osc_control[supply_state_pkg::OSC_RC_ON_XT_FAIL]) begin
      xt_fail_switched <= 1'b1;
    end else if (!xtal_fail_flag) begin
      xt_fail_switched <= 1'b0;
    end
  end

  // (R16) RC forced on backup
  assign use_rc_osc = osc_control[supply_state_pkg::OSC_SELECT_RC] || xt_fail_switched ||
                      (in_backup && osc_control[supply_state_pkg::OSC_RC_ON_BACKUP]);
  assign autocal_mode = osc_control[supply_state_pkg::OSC_MODE_HI:supply_state_pkg::OSC_MODE_LO];

  // ----------------------------------------------------------------
  // Level interrupts
  // ----------------------------------------------------------------
  // (R20) Cell-low interrupt
  // (R24) Level until flag cleared
  assign cell_low_irq = flags[1] && irq_mask[supply_state_pkg::MSK_CELL_LOW];
  assign xtal_fail_irq = xtal_fail_flag && irq_mask[supply_state_pkg::MSK_XTAL_FAIL];
  // (R06) Autocal failure interrupt
  assign autocal_fail_irq = autocal_fail_flag && irq_mask[supply_state_pkg::MSK_AUTOCAL_FAIL];

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  logic [7:0] status_word;

  always_comb begin
    status_word = 8'h00;
    status_word[supply_state_pkg::STS_ON_BACKUP] = in_backup;
    for (int i = 0; i < NUM_FLAGS; i++) begin
      status_word[FLAG_POS[i]] = flags[i];
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (rd && serial_enable) begin
      unique case (addr)
        supply_state_pkg::ADDR_STATUS: next_rdata = status_word;
        supply_state_pkg::ADDR_CONTROL: next_rdata = control;
        supply_state_pkg::ADDR_IRQ_MASK: next_rdata = irq_mask;
        supply_state_pkg::ADDR_OSC_CONTROL: next_rdata = osc_control;
        supply_state_pkg::ADDR_OSC_STATUS: begin
          next_rdata[supply_state_pkg::OST_XTAL_FAIL] = xtal_fail_flag;
          next_rdata[supply_state_pkg::OST_AUTOCAL_FAIL] = autocal_fail_flag;
        end
        supply_state_pkg::ADDR_THRESHOLD: begin
          next_rdata[supply_state_pkg::THR_HI:supply_state_pkg::THR_LO] = threshold;
        end
        supply_state_pkg::ADDR_IO_BACKUP: begin
          next_rdata[supply_state_pkg::IOB_SERIAL_ON_BACKUP] = serial_on_backup;
        end
        supply_state_pkg::ADDR_ANALOG_STATUS: begin
          next_rdata[supply_state_pkg::ANS_ABOVE] = above_thr;
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Data appears only in the cycle after the read strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

// ===== design/supply_state_pkg.sv
// Constants, register map and state encodings for the supply state and flag block
package supply_state_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h0F;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h12;
  localparam logic [7:0] ADDR_OSC_CONTROL = 8'h1C;
  localparam logic [7:0] ADDR_OSC_STATUS = 8'h1D;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h21;
  localparam logic [7:0] ADDR_IO_BACKUP = 8'h27;
  localparam logic [7:0] ADDR_ANALOG_STATUS = 8'h2F;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STS_ON_BACKUP = 7;
  localparam int STS_WATCHDOG = 5;
  localparam int STS_CELL_LOW = 4;
  localparam int STS_COUNTDOWN = 3;
  localparam int STS_ALARM = 2;
  localparam int STS_EXTERNAL = 1;

  // Control, mask, oscillator, threshold, backup I/O and analog status fields
  localparam int CTL_CLEAR_ON_READ = 2;
  localparam int CTL_POLARITY = 5;
  localparam int MSK_CELL_LOW = 2;
  localparam int MSK_XTAL_FAIL = 1;
  localparam int MSK_AUTOCAL_FAIL = 0;
  localparam int OSC_SELECT_RC = 7;
  localparam int OSC_MODE_HI = 6;
  localparam int OSC_MODE_LO = 5;
  localparam int OSC_RC_ON_BACKUP = 4;
  localparam int OSC_RC_ON_XT_FAIL = 3;
  localparam int OST_XTAL_FAIL = 1;
  localparam int OST_AUTOCAL_FAIL = 0;
  localparam int THR_HI = 7;
  localparam int THR_LO = 4;
  localparam int IOB_SERIAL_ON_BACKUP = 7;
  localparam int ANS_ABOVE = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_OSC_CONTROL = 8'h00;
  localparam logic [3:0] RST_THRESHOLD = 4'hF;
  localparam logic RST_SERIAL_ON_BACKUP = 1'b1;
  localparam logic RST_XTAL_FAIL = 1'b1;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_POR = 2'h0,
    PWR_MAIN = 2'h1,
    PWR_BACKUP = 2'h2
  } power_state_t;

endpackage

// ===== test/supply_state_chk.sv
// Port checker for the supply state and flag block
`timescale 1ns/1ns
module supply_state_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic main_above_start_level,
  input wire logic main_below_reset_level,
  input wire logic main_below_switch_fall_level,
  input wire logic main_above_switch_rise_level,
  input wire logic backup_above_switch_level,
  input wire logic backup_below_reset_level,
  input wire logic [1:0] power_state,
  input wire logic hold_in_reset,
  input wire logic on_backup_supply_flag,
  input wire logic serial_enable,
  input wire logic cell_low_irq,
  input wire logic xtal_fail_irq,
  input wire logic autocal_fail_irq
);
  wire in_por = power_state == supply_state_pkg::PWR_POR;
  wire in_main = power_state == supply_state_pkg::PWR_MAIN;
  wire in_bak = power_state == supply_state_pkg::PWR_BACKUP;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Power state transitions
  // ----------------------------------------------------------------
  property p_start;
    $past(in_por) && in_main |-> $past(main_above_start_level, 3);
  endproperty
  a_start: assert property (p_start) else $error("main entered without start level");
  property p_no_jump;
    $past(in_por) |-> !in_bak;
  endproperty
  a_no_jump: assert property (p_no_jump) else $error("backup entered from reset");
  property p_main_por;
    $past(in_main) && in_por |->
      $past(main_below_reset_level, 3) && !$past(backup_above_switch_level, 3);
  endproperty
  a_main_por: assert property (p_main_por) else $error("bad return to reset");
  property p_to_bak;
    $past(in_main) && in_bak |->
      $past(main_below_switch_fall_level, 3) && $past(backup_above_switch_level, 3);
  endproperty
  a_to_bak: assert property (p_to_bak) else $error("bad switch to backup");
  property p_bak_main;
    $past(in_bak) && in_main |-> $past(main_above_switch_rise_level, 3);
  endproperty
  a_bak_main: assert property (p_bak_main) else $error("bad return to main");
  property p_bak_por;
    $past(in_bak) && in_por |-> $past(backup_below_reset_level, 3);
  endproperty
  a_bak_por: assert property (p_bak_por) else $error("bad backup to reset");

  // ----------------------------------------------------------------
  // Status outputs and bus gating
  // ----------------------------------------------------------------
  property p_flag;
    on_backup_supply_flag == in_bak;
  endproperty
  a_flag: assert property (p_flag) else $error("backup flag wrong");
  property p_por_hold;
    in_por |-> hold_in_reset && !serial_enable;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset state not held");
  property p_refuse;
    $past(rd) && !$past(serial_enable) |-> rdata == 8'h00;
  endproperty
  a_refuse: assert property (p_refuse) else $error("gated read returned data");
  property p_level;
    $fell(cell_low_irq) || $fell(xtal_fail_irq) || $fell(autocal_fail_irq) |->
      $past(wr) || $past(rd) || $past(in_por) || in_por;
  endproperty
  a_level: assert property (p_level) else $error("level interrupt dropped");

  c_up: cover property ($past(in_por) && in_main);
  c_bak: cover property ($past(in_main) && in_bak);
  c_low: cover property ($rose(cell_low_irq));
endmodule

bind supply_state_and_irq_flags supply_state_chk chk (
  .clk, .reset, .wr, .rd, .rdata,
  .main_above_start_level, .main_below_reset_level, .main_below_switch_fall_level,
  .main_above_switch_rise_level, .backup_above_switch_level, .backup_below_reset_level,
  .power_state, .hold_in_reset, .on_backup_supply_flag, .serial_enable,
  .cell_low_irq, .xtal_fail_irq, .autocal_fail_irq
);

// ===== test/supply_model.sv
// Comparator model turning supply voltages into threshold levels
`timescale 1ns/1ns
module supply_model #(
  parameter int START_MV = 2000,
  parameter int RST_MV = 1500,
  parameter int FALL_SW_MV = 1800,
  parameter int RISE_SW_MV = 2200,
  parameter int BK_SW_MV = 2000,
  parameter int BK_RST_MV = 1400,
  parameter int CMP_RISE_MV = 2600,
  parameter int CMP_FALL_MV = 2400
) (
  input int main_mv,
  input int bk_mv,
  output logic m_start,
  output logic m_rst,
  output logic m_fall,
  output logic m_rise,
  output logic b_sw,
  output logic b_rst,
  output logic b_rise,
  output logic b_fall
);
  assign m_start = main_mv > START_MV;
  assign m_rst = main_mv < RST_MV;
  // Rise level sits above fall level for hysteresis
  assign m_fall = main_mv < FALL_SW_MV;
  assign m_rise = main_mv > RISE_SW_MV;
  assign b_sw = bk_mv > BK_SW_MV;
  assign b_rst = bk_mv < BK_RST_MV;
  assign b_rise = bk_mv > CMP_RISE_MV;
  assign b_fall = bk_mv < CMP_FALL_MV;
endmodule

// ===== test/testbench.sv
// Self-checking bench for the supply state and flag block
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] ev = 6'h00;
  int main_mv = 0;
  int bk_mv = 0;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] rdata;
  logic [1:0] power_state, autocal_mode_select;
  localparam logic [7:0] STS = supply_state_pkg::ADDR_STATUS;
  localparam logic [1:0] POR = supply_state_pkg::PWR_POR;
  localparam logic [1:0] MAIN = supply_state_pkg::PWR_MAIN;
  localparam logic [1:0] BAK = supply_state_pkg::PWR_BACKUP;
  logic [3:0] thr;
  logic hold_in_reset, on_bak, use_rc, ser_en, above, low_irq, xt_irq, ac_irq;
  logic m_start, m_rst, m_fall, m_rise, b_sw, b_rst, b_rise, b_fall;

  always #25 clk = ~clk;

  supply_model cmp (.main_mv, .bk_mv, .m_start, .m_rst, .m_fall, .m_rise, .b_sw, .b_rst,
    .b_rise, .b_fall);

  supply_state_and_irq_flags uut (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
    .main_above_start_level(m_start),
    .main_below_reset_level(m_rst), .main_below_switch_fall_level(m_fall),
    .main_above_switch_rise_level(m_rise), .backup_above_switch_level(b_sw),
    .backup_below_reset_level(b_rst), .backup_above_rise_threshold(b_rise),
    .backup_below_fall_threshold(b_fall), .watchdog_event(ev[0]), .countdown_event(ev[1]),
    .alarm_event(ev[2]), .external_event(ev[3]), .xtal_fail_event(ev[4]),
    .autocal_fail_event(ev[5]), .power_state, .hold_in_reset,
    .on_backup_supply_flag(on_bak), .use_rc_osc(use_rc), .autocal_mode(autocal_mode_select),
    .serial_enable(ser_en), .backup_threshold_select(thr), .backup_above_threshold(above),
    .cell_low_irq(low_irq), .xtal_fail_irq(xt_irq), .autocal_fail_irq(ac_irq));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [5:0] e, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    ev <= e;
    @(posedge clk);
    rd <= 1'b0;
    ev <= 6'h00;
    @(negedge clk);
    check("rdata", rdata, exp);
  endtask

  task automatic fire(input logic [5:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 6'h00;
  endtask

  task automatic go(input int m, input int b, input logic [1:0] s);
    @(posedge clk);
    main_mv <= m;
    bk_mv <= b;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 20 && power_state !== s; i++) @(posedge clk);
    @(negedge clk);
    check("power_state", 8'(power_state), 8'(s));
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(20000 * 50);
    num_errors++;
    wrap_up();
  end

  initial begin
    settle(2);
    reset <= 1'b0;
    check("hold_in_reset", 8'(hold_in_reset), 8'h01);
    go(0, 3000, POR);
    rd_chk(supply_state_pkg::ADDR_IO_BACKUP, 6'h00, 8'h00);
    go(3300, 3000, MAIN);
    rd_chk(supply_state_pkg::ADDR_IO_BACKUP, 6'h00, 8'h80);
    check("threshold", 8'(thr), 8'h0F);
    $display("test power up done");
    wr_reg(supply_state_pkg::ADDR_CONTROL, 8'h04);
    fire(6'h0F);
    rd_chk(STS, 6'h00, 8'h2E);
    rd_chk(STS, 6'h04, 8'h00);
    rd_chk(STS, 6'h00, 8'h04);
    rd_chk(STS, 6'h00, 8'h00);
    rd_chk(supply_state_pkg::ADDR_OSC_STATUS, 6'h00, 8'h02);
    wr_reg(supply_state_pkg::ADDR_CONTROL, 8'h00);
    fire(6'h02);
    wr_reg(STS, 8'hFF);
    rd_chk(STS, 6'h00, 8'h08);
    wr_reg(STS, 8'hF7);
    rd_chk(STS, 6'h00, 8'h00);
    $display("test flag clearing done");
    wr_reg(supply_state_pkg::ADDR_IRQ_MASK, 8'h07);
    fire(6'h20);
    settle(1);
    check("osc irqs", 8'({xt_irq, ac_irq}), 8'h03);
    rd_chk(supply_state_pkg::ADDR_OSC_STATUS, 6'h00, 8'h03);
    wr_reg(supply_state_pkg::ADDR_OSC_CONTROL, 8'h08);
    wr_reg(supply_state_pkg::ADDR_OSC_STATUS, 8'h00);
    settle(1);
    check("osc irqs", 8'({xt_irq, ac_irq, use_rc}), 8'h00);
    fire(6'h10);
    settle(1);
    check("use_rc_osc", 8'(use_rc), 8'h01);
    wr_reg(supply_state_pkg::ADDR_OSC_STATUS, 8'h00);
    $display("test oscillator flags done");
    check("above", 8'({above, low_irq}), 8'h02);
    wr_reg(supply_state_pkg::ADDR_THRESHOLD, 8'h70);
    rd_chk(supply_state_pkg::ADDR_ANALOG_STATUS, 6'h00, 8'h08);
    check("threshold", 8'(thr), 8'h07);
    go(3300, 2500, MAIN);
    check("above", 8'({above, low_irq}), 8'h02);
    go(3300, 2300, MAIN);
    check("above", 8'({above, low_irq}), 8'h01);
    rd_chk(STS, 6'h00, 8'h10);
    wr_reg(supply_state_pkg::ADDR_CONTROL, 8'h20);
    settle(6);
    wr_reg(STS, 8'hEF);
    settle(1);
    check("cell_low_irq", 8'(low_irq), 8'h00);
    go(3300, 3000, MAIN);
    check("above", 8'({above, low_irq}), 8'h03);
    wr_reg(supply_state_pkg::ADDR_CONTROL, 8'h00);
    wr_reg(STS, 8'hEF);
    $display("test comparator done");
    wr_reg(supply_state_pkg::ADDR_OSC_CONTROL, 8'h50);
    go(1900, 3000, MAIN);
    go(1700, 3000, BAK);
    check("backup outs", 8'({on_bak, use_rc, ser_en}), 8'h07);
    check("autocal_mode", 8'(autocal_mode_select), 8'h02);
    rd_chk(STS, 6'h00, 8'h80);
    wr_reg(supply_state_pkg::ADDR_IO_BACKUP, 8'h00);
    rd_chk(STS, 6'h00, 8'h00);
    wr_reg(supply_state_pkg::ADDR_IO_BACKUP, 8'h80);
    go(2000, 3000, BAK);
    go(2300, 3000, MAIN);
    check("use_rc_osc", 8'(use_rc), 8'h00);
    rd_chk(supply_state_pkg::ADDR_IO_BACKUP, 6'h00, 8'h00);
    $display("test switchover done");
    go(3300, 1000, MAIN);
    go(1000, 1000, POR);
    go(3300, 3000, MAIN);
    go(1000, 3000, BAK);
    go(1000, 1000, POR);
    go(3300, 3000, MAIN);
    rd_chk(supply_state_pkg::ADDR_OSC_CONTROL, 6'h00, 8'h00);
    rd_chk(supply_state_pkg::ADDR_OSC_STATUS, 6'h00, 8'h02);
    $display("test power down done");
    wrap_up();
  end
endmodule
